// [rtl/mwm_top.sv]
// Motion window monitor: parameter store, window checks and status word
`timescale 1ns/100ps
module mwm_top
    import mwm_pkg::*;
#(
    parameter int TICK_CYCLES = mwm_pkg::TICK_CYCLES
)
(
    input  wire logic               CLK,
    input  wire logic               RESET,
    input  wire logic               CE,
    input  wire mwm_pkg::mwm_preq_s PAR_REQ,
    output logic [31:0]             PAR_RDATA,
    output logic                    PAR_ACK,
    output logic                    PAR_ERR,
    input  wire mwm_pkg::mwm_motion_s MOTION,
    input  wire logic [31:0]        POS_SCALE,
    input  wire logic               VEL_MODE,
    input  wire logic               RAMP_ACTIVE,
    output logic [15:0]             STATUS_WORD,
    output mwm_pkg::mwm_flags_s     FLAGS
);

    // ******************************
    // Helpers
    // ******************************
    function automatic logic [32:0] abs_diff(input logic signed [31:0] a,
                                             input logic signed [31:0] b);
        logic signed [33:0] d;
        d = {{2{a[31]}}, a} - {{2{b[31]}}, b};
        return d[33] ? 33'(-d) : d[32:0];  // [RULE14]
    endfunction

    function automatic logic [3:0] win_slot(input logic [15:0] n);
        logic [3:0] s;
        s = 4'h0;
        unique case (n)
            PN_POS_ERR_WIN:    s = 4'h8 | 4'(WI_POS_ERR);
            PN_POS_REACH_WIN:  s = 4'h8 | 4'(WI_POS_REACH);
            PN_VEL_ERR_WIN:    s = 4'h8 | 4'(WI_VEL_ERR);
            PN_OVERSPEED_LIM:  s = 4'h8 | 4'(WI_OVERSPEED);
            PN_VEL_REACH_WIN:  s = 4'h8 | 4'(WI_VEL_REACH);
            PN_STANDSTILL_LIM: s = 4'h8 | 4'(WI_STANDSTILL);
            default:           s = 4'h0;
        endcase
        return s;
    endfunction

    function automatic logic [3:0] dwell_slot(input logic [15:0] n);
        logic [3:0] s;
        s = 4'h0;
        unique case (n)
            PN_POS_ERR_DWELL:    s = 4'h8 | 4'(DI_POS_ERR);
            PN_POS_REACH_DWELL:  s = 4'h8 | 4'(DI_POS_REACH);
            PN_STANDSTILL_DWELL: s = 4'h8 | 4'(DI_STANDSTILL);
            PN_VEL_ERR_DWELL:    s = 4'h8 | 4'(DI_VEL_ERR);
            PN_VEL_REACH_DWELL:  s = 4'h8 | 4'(DI_VEL_REACH);
            default:             s = 4'h0;
        endcase
        return s;
    endfunction

    // ******************************
    // Declarations
    // ******************************
    logic [31:0]      win_q [NUM_WIN];
    logic [15:0]      dwell_q [NUM_DWELL];
    logic [3:0]       wslot;
    logic [3:0]       dslot;
    logic [32:0]      win_inc_q;
    logic [63:0]      scale_prod;
    logic [32:0]      pos_err_abs;
    logic [32:0]      pos_tgt_abs;
    logic [32:0]      vel_err_abs;
    logic [32:0]      vel_abs;
    mwm_flags_s       raw_q;
    logic             vel_mode_q;
    logic [NUM_DWELL-1:0] qual;
    logic             reached;
    logic             follow_err;

    assign wslot = win_slot(PAR_REQ.num);
    assign dslot = dwell_slot(PAR_REQ.num);

    // ******************************
    // Parameter writes
    // ******************************
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            for (int i = 0; i < NUM_WIN; i++)
                win_q[i] <= RST_WIN;
            for (int i = 0; i < NUM_DWELL; i++)
                dwell_q[i] <= RST_DWELL;
        end
        else if (CE && PAR_REQ.wr)
        begin
            if (wslot[3])
                win_q[wslot[2:0]] <= PAR_REQ.wdata;
            if (dslot[3])
                dwell_q[dslot[2:0]] <= PAR_REQ.wdata[15:0];
        end
    end

    // ******************************
    // Parameter reads and answers
    // ******************************
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            PAR_RDATA <= 32'h0000_0000;
            PAR_ACK   <= 1'b0;
            PAR_ERR   <= 1'b0;
        end
        else if (CE)
        begin
            PAR_ACK <= PAR_REQ.wr || PAR_REQ.rd;
            PAR_ERR <= 1'b0;
            if (PAR_REQ.rd)
            begin
                if (wslot[3])
                    PAR_RDATA <= win_q[wslot[2:0]];
                else if (dslot[3])
                    PAR_RDATA <= {16'h0000, dwell_q[dslot[2:0]]};
                else if (PAR_REQ.num == PN_STATUS_WORD)
                    PAR_RDATA <= {16'h0000, STATUS_WORD};
                else
                begin
                    PAR_RDATA <= 32'h0000_0000;
                    PAR_ERR   <= 1'b1;
                end
            end
            else if (PAR_REQ.wr)
                PAR_ERR <= !(wslot[3] || dslot[3]);
        end
    end

    // ******************************
    // Window scaling into increments
    // ******************************
    assign scale_prod = {32'h0000_0000, win_q[WI_POS_ERR]} * {32'h0000_0000, POS_SCALE};

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            win_inc_q <= 33'h0_0000_0000;
        else if (CE)
        begin
            if (|scale_prod[63:SCALE_FRAC+33])
                win_inc_q <= 33'h1_FFFF_FFFF;  // [RULE2]
            else
                win_inc_q <= scale_prod[SCALE_FRAC+32:SCALE_FRAC];  // [RULE2]
        end
    end

    // ******************************
    // Window comparisons
    // ******************************
    assign pos_err_abs = abs_diff(MOTION.actual_pos, MOTION.demand_pos);
    assign pos_tgt_abs = abs_diff(MOTION.actual_pos, MOTION.target_pos);
    assign vel_err_abs = abs_diff(MOTION.target_vel, MOTION.actual_vel);
    assign vel_abs     = abs_diff(MOTION.actual_vel, 32'sh0000_0000);

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            raw_q      <= '0;
            vel_mode_q <= 1'b0;
        end
        else if (CE)
        begin
            vel_mode_q        <= VEL_MODE;
            raw_q.pos_err     <= pos_err_abs > win_inc_q;  // [RULE1] [RULE14]
            raw_q.pos_reach   <= pos_tgt_abs <= {1'b0, win_q[WI_POS_REACH]};  // [RULE5]
            raw_q.vel_err     <= VEL_MODE &&
                                 vel_err_abs > {1'b0, win_q[WI_VEL_ERR]};  // [RULE12]
            raw_q.vel_reach   <= !RAMP_ACTIVE &&
                                 vel_err_abs <= {1'b0, win_q[WI_VEL_REACH]};  // [RULE10]
            raw_q.moving      <= vel_abs > {1'b0, win_q[WI_STANDSTILL]};  // [RULE7]
            raw_q.overspeed   <= vel_abs > {1'b0, win_q[WI_OVERSPEED]};  // [RULE11]
        end
    end

    // ******************************
    // Dwell qualifiers
    // ******************************
    mwm_dwell #(.TICKS(TICK_CYCLES)) u_pos_err_dwell
    (
        .clk    (CLK),
        .reset  (RESET),
        .ce     (CE),
        .cond   (raw_q.pos_err),
        .dwell  (dwell_q[DI_POS_ERR]),
        .flag_q (qual[DI_POS_ERR])
    );

    mwm_dwell #(.TICKS(TICK_CYCLES)) u_pos_reach_dwell
    (
        .clk    (CLK),
        .reset  (RESET),
        .ce     (CE),
        .cond   (raw_q.pos_reach),
        .dwell  (dwell_q[DI_POS_REACH]),
        .flag_q (qual[DI_POS_REACH])
    );

    mwm_dwell #(.TICKS(TICK_CYCLES)) u_standstill_dwell
    (
        .clk    (CLK),
        .reset  (RESET),
        .ce     (CE),
        .cond   (raw_q.moving),
        .dwell  (dwell_q[DI_STANDSTILL]),
        .flag_q (qual[DI_STANDSTILL])
    );

    mwm_dwell #(.TICKS(TICK_CYCLES)) u_vel_err_dwell
    (
        .clk    (CLK),
        .reset  (RESET),
        .ce     (CE),
        .cond   (raw_q.vel_err),
        .dwell  (dwell_q[DI_VEL_ERR]),
        .flag_q (qual[DI_VEL_ERR])
    );

    mwm_dwell #(.TICKS(TICK_CYCLES)) u_vel_reach_dwell
    (
        .clk    (CLK),
        .reset  (RESET),
        .ce     (CE),
        .cond   (raw_q.vel_reach),
        .dwell  (dwell_q[DI_VEL_REACH]),
        .flag_q (qual[DI_VEL_REACH])
    );

    // ******************************
    // Status word and flag outputs
    // ******************************
    assign reached    = vel_mode_q ? qual[DI_VEL_REACH] : qual[DI_POS_REACH];  // [RULE6] [RULE9]
    assign follow_err = vel_mode_q ? qual[DI_VEL_ERR] : qual[DI_POS_ERR];  // [RULE3] [RULE12]

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            STATUS_WORD <= RST_STATUS;
            FLAGS       <= '0;
        end
        else if (CE)
        begin
            STATUS_WORD                <= 16'h0000;
            STATUS_WORD[SW_REACHED]    <= reached;  // [RULE6] [RULE9]
            STATUS_WORD[SW_STANDSTILL] <= !qual[DI_STANDSTILL];  // [RULE7]
            STATUS_WORD[SW_FOLLOW_ERR] <= follow_err;  // [RULE3] [RULE4]
            FLAGS.pos_err              <= qual[DI_POS_ERR];
            FLAGS.vel_err              <= qual[DI_VEL_ERR];
            FLAGS.pos_reach            <= qual[DI_POS_REACH];
            FLAGS.vel_reach            <= qual[DI_VEL_REACH];
            FLAGS.moving               <= qual[DI_STANDSTILL];
            FLAGS.overspeed            <= raw_q.overspeed;  // [RULE11]
        end
    end

    // ******************************
    // Assertions
    // ******************************
    property p_fe_cause;
        @(posedge CLK) disable iff (RESET)
        $rose(STATUS_WORD[SW_FOLLOW_ERR]) && !$past(vel_mode_q) |-> $past(raw_q.pos_err, 2);
    endproperty
    a_fe_cause: assert property (p_fe_cause)  // [RULE1]
        else $error("following error bit rose without a position error");

    property p_unity_scale;
        @(posedge CLK) disable iff (RESET)
        CE && POS_SCALE == SCALE_ONE |=> win_inc_q == {1'b0, $past(win_q[WI_POS_ERR])};
    endproperty
    a_unity_scale: assert property (p_unity_scale)  // [RULE2]
        else $error("unity scale changed the error window");

    property p_fe_bit;
        @(posedge CLK) disable iff (RESET)
        CE && !vel_mode_q && qual[DI_POS_ERR] |=> STATUS_WORD[SW_FOLLOW_ERR];
    endproperty
    a_fe_bit: assert property (p_fe_bit)  // [RULE3]
        else $error("qualified position error did not set bit 13");

    property p_pos_edge;
        @(posedge CLK) disable iff (RESET)
        CE && pos_tgt_abs == {1'b0, win_q[WI_POS_REACH]} |=> raw_q.pos_reach;
    endproperty
    a_pos_edge: assert property (p_pos_edge)  // [RULE5] [RULE14]
        else $error("position on the reach limit not counted inside");

    property p_reach_cause;
        @(posedge CLK) disable iff (RESET)
        $rose(STATUS_WORD[SW_REACHED]) && !$past(vel_mode_q) |-> $past(raw_q.pos_reach, 2);
    endproperty
    a_reach_cause: assert property (p_reach_cause)  // [RULE6]
        else $error("target reached rose without the position inside");

    property p_still;
        @(posedge CLK) disable iff (RESET)
        CE && !raw_q.moving ##1 CE |=> STATUS_WORD[SW_STANDSTILL];
    endproperty
    a_still: assert property (p_still)  // [RULE7]
        else $error("standstill bit low while speed below limit");

    property p_ramp_blocks;
        @(posedge CLK) disable iff (RESET)
        CE && RAMP_ACTIVE |=> !raw_q.vel_reach;
    endproperty
    a_ramp_blocks: assert property (p_ramp_blocks)  // [RULE10]
        else $error("velocity reach seen during a ramp");

    property p_vel_reach;
        @(posedge CLK) disable iff (RESET)
        CE && vel_mode_q && qual[DI_VEL_REACH] |=> STATUS_WORD[SW_REACHED];
    endproperty
    a_vel_reach: assert property (p_vel_reach)  // [RULE9]
        else $error("velocity reach did not set bit 10");

    property p_overspeed;
        @(posedge CLK) disable iff (RESET)
        CE && vel_abs > {1'b0, win_q[WI_OVERSPEED]} ##1 CE |=> FLAGS.overspeed;
    endproperty
    a_overspeed: assert property (p_overspeed)  // [RULE11]
        else $error("overspeed not flagged");

    property p_vel_err_mode;
        @(posedge CLK) disable iff (RESET)
        CE && !VEL_MODE |=> !raw_q.vel_err;
    endproperty
    a_vel_err_mode: assert property (p_vel_err_mode)  // [RULE12]
        else $error("velocity error outside velocity mode");

endmodule

// [pkg/mwm_pkg.sv]
// Constants and types for the motion window monitor
// Operation
// RULE1 - A position following error is flagged when actual position lies outside a band of the error window centred on the position demand.
// RULE2 - The user-unit following error window is scaled into encoder increments by the position scaling factor before the comparison.
// RULE3 - A following error lasting longer than the following error dwell in milliseconds sets status word bit 13.
// RULE4 - Beyond the status flag, any drive reaction to a following error is left to the surrounding design.
// RULE5 - The target position counts as reached while the actual position lies within the reach window on either side of the target.
// RULE6 - Status word bit 10 is set only after the position has stayed inside the reach window for the reach dwell in milliseconds.
// RULE7 - Status word bit 12 clears when the speed stays above the standstill limit beyond its dwell, and is set while the speed is below it.
// RULE8 - The standstill dwell is counted in units of one millisecond.
// RULE9 - Status word bit 10 is set when the velocity difference stays inside the velocity reach window longer than the velocity reach dwell.
// RULE10 - The velocity reach check applies only once an acceleration or braking phase has ended, in velocity units.
// RULE11 - An overspeed error is raised when the actual speed exceeds the overspeed limit.
// RULE12 - In velocity mode a separate velocity error window with its own millisecond dwell detects velocity tracking errors.
// RULE13 - Each dwell timer restarts from zero when its condition lapses, so a flag changes only after an unbroken interval. Here a flag drops on any lapse.
// RULE14 - Window checks use the absolute difference, and equality with the limit counts as inside.
package mwm_pkg;

    // ******************************
    // Parameter numbers
    // ******************************
    localparam logic [15:0] PN_POS_ERR_WIN      = 16'h00A3;
    localparam logic [15:0] PN_POS_REACH_WIN    = 16'h00A5;
    localparam logic [15:0] PN_VEL_ERR_WIN      = 16'h00A7;
    localparam logic [15:0] PN_OVERSPEED_LIM    = 16'h00A9;
    localparam logic [15:0] PN_VEL_REACH_WIN    = 16'h00AB;
    localparam logic [15:0] PN_STANDSTILL_LIM   = 16'h00AD;
    localparam logic [15:0] PN_POS_ERR_DWELL    = 16'h00AE;
    localparam logic [15:0] PN_POS_REACH_DWELL  = 16'h00AF;
    localparam logic [15:0] PN_STANDSTILL_DWELL = 16'h00B0;
    localparam logic [15:0] PN_VEL_ERR_DWELL    = 16'h00B1;
    localparam logic [15:0] PN_VEL_REACH_DWELL  = 16'h00B2;
    localparam logic [15:0] PN_STATUS_WORD      = 16'h00C0;

    // ******************************
    // Array slots of windows and dwells
    // ******************************
    localparam int NUM_WIN         = 6;
    localparam int NUM_DWELL       = 5;
    localparam int WI_POS_ERR      = 0;
    localparam int WI_POS_REACH    = 1;
    localparam int WI_VEL_ERR      = 2;
    localparam int WI_OVERSPEED    = 3;
    localparam int WI_VEL_REACH    = 4;
    localparam int WI_STANDSTILL   = 5;
    localparam int DI_POS_ERR      = 0;
    localparam int DI_POS_REACH    = 1;
    localparam int DI_STANDSTILL   = 2;
    localparam int DI_VEL_ERR      = 3;
    localparam int DI_VEL_REACH    = 4;

    // ******************************
    // Reset values and layout
    // ******************************
    localparam logic [31:0] RST_WIN     = 32'h0000_0000;
    localparam logic [15:0] RST_DWELL   = 16'h0000;
    localparam logic [15:0] RST_STATUS  = 16'h1000;
    localparam int          SW_REACHED  = 10;
    localparam int          SW_STANDSTILL = 12;
    localparam int          SW_FOLLOW_ERR = 13;
    localparam int          SCALE_FRAC  = 16;
    localparam logic [31:0] SCALE_ONE   = 32'h0001_0000;

    // ******************************
    // Timing
    // ******************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int MS_NS         = 1000000;
    localparam int TICK_CYCLES   = MS_NS / CLK_PERIOD_NS;
    localparam int PRE_W         = 15;

    // ******************************
    // Carriers
    // ******************************
    typedef struct packed {
        logic signed [31:0] demand_pos;
        logic signed [31:0] target_pos;
        logic signed [31:0] actual_pos;
        logic signed [31:0] target_vel;
        logic signed [31:0] actual_vel;
    } mwm_motion_s;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] num;
        logic [31:0] wdata;
    } mwm_preq_s;

    typedef struct packed {
        logic pos_err;
        logic vel_err;
        logic pos_reach;
        logic vel_reach;
        logic moving;
        logic overspeed;
    } mwm_flags_s;

endpackage

// [rtl/mwm_dwell.sv]
// Millisecond dwell qualifier for one window condition
`timescale 1ns/100ps
module mwm_dwell
    import mwm_pkg::*;
#(
    parameter int TICKS = mwm_pkg::TICK_CYCLES
)
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        ce,
    input  wire logic        cond,
    input  wire logic [15:0] dwell,
    output logic             flag_q
);

    logic [PRE_W-1:0] pre_q;
    logic [16:0]      ms_q;
    logic             ms_tick;

    assign ms_tick = (pre_q == PRE_W'(TICKS - 1));

    // ******************************
    // Prescaler and millisecond count
    // ******************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pre_q <= '0;
            ms_q  <= '0;
        end
        else if (ce)
        begin
            if (!cond)
            begin
                pre_q <= '0;  // [RULE13]
                ms_q  <= '0;  // [RULE13]
            end
            else if (ms_q < {1'b0, dwell})
            begin
                pre_q <= ms_tick ? '0 : pre_q + 1'b1;
                if (ms_tick)
                    ms_q <= ms_q + 1'b1;  // [RULE8]
            end
        end
    end

    // ******************************
    // Qualified flag
    // ******************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            flag_q <= 1'b0;
        else if (ce)
            flag_q <= cond && (ms_q >= {1'b0, dwell});  // [RULE13]
    end

    property p_lapse_clears;
        @(posedge clk) disable iff (reset)
        ce && !cond |=> !flag_q;
    endproperty
    a_lapse_clears: assert property (p_lapse_clears)  // [RULE13]
        else $error("dwell flag stayed up after its condition lapsed");

    property p_rise_after_dwell;
        @(posedge clk) disable iff (reset)
        $rose(flag_q) |-> $past(cond) && ($past(ms_q) >= {1'b0, $past(dwell)});
    endproperty
    a_rise_after_dwell: assert property (p_rise_after_dwell)  // [RULE13]
        else $error("dwell flag rose before the dwell elapsed");

    property p_ms_step;
        @(posedge clk) disable iff (reset)
        ce && cond && !ms_tick |=> ms_q == $past(ms_q);
    endproperty
    a_ms_step: assert property (p_ms_step)  // [RULE8]
        else $error("millisecond count moved between ticks");

endmodule

// [bench/mwm_ctrl_model.sv]
// Fieldbus controller model issuing parameter accesses
`timescale 1ns/100ps
module mwm_ctrl_model
(
    input  wire logic          clk,
    input  wire logic          ack,
    output mwm_pkg::mwm_preq_s req
);
    import mwm_pkg::*;

    initial req = '{wr: 1'b0, rd: 1'b0, num: 16'hFFFF, wdata: 32'hFFFF_FFFF};

    // One access: one-cycle strobe, bounded wait for the answer, one idle edge
    task automatic access(input logic w, input logic r, input logic [15:0] n,
                          input logic [31:0] d);
        int i;
        req = '{wr: w, rd: r, num: n, wdata: d};
        @(posedge clk);
        #1;
        // Released lines show no stale value
        req = '{wr: 1'b0, rd: 1'b0, num: ~n, wdata: ~d};
        for (i = 0; i < 4 && ack !== 1'b1; i++)
        begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1;
    endtask
endmodule

// [bench/mwm_top_tb.sv]
// Self-checking bench for the motion window monitor
`timescale 1ns/100ps
module mwm_top_tb;
    import mwm_pkg::*;
    localparam int TK = 4;
    typedef struct packed { logic err; logic chk; logic [31:0] d; } mwm_exp_s;
    localparam logic [15:0] PN [11] = '{PN_POS_ERR_WIN, PN_POS_REACH_WIN, PN_VEL_ERR_WIN,
        PN_OVERSPEED_LIM, PN_VEL_REACH_WIN, PN_STANDSTILL_LIM, PN_POS_ERR_DWELL,
        PN_POS_REACH_DWELL, PN_STANDSTILL_DWELL, PN_VEL_ERR_DWELL, PN_VEL_REACH_DWELL};
    localparam logic [31:0] VAL [11] = '{32'hA, 32'h5, 32'h32, 32'hC8, 32'hA, 32'h64,
        32'h2, 32'h0, 32'h1, 32'h0, 32'h0};

    logic        clk         = 1'b0;
    logic        reset       = 1'b1;
    logic        ce          = 1'b1;
    logic [31:0] pos_scale   = SCALE_ONE;
    logic        vel_mode    = 1'b0;
    logic        ramp_active = 1'b0;
    mwm_motion_s mot         = '0;
    mwm_preq_s   preq;
    logic [31:0] rdata;
    logic        ack;
    logic        err;
    logic [15:0] sw;
    mwm_flags_s  flg;
    mwm_exp_s    q [$];
    mwm_exp_s    e;
    int          n_mismatch  = 0;
    int          check_count = 0;

    initial forever #25 clk = ~clk;

    mwm_top #(.TICK_CYCLES(TK)) dut (.CLK(clk), .RESET(reset), .CE(ce), .PAR_REQ(preq),
        .PAR_RDATA(rdata), .PAR_ACK(ack), .PAR_ERR(err), .MOTION(mot),
        .POS_SCALE(pos_scale), .VEL_MODE(vel_mode), .RAMP_ACTIVE(ramp_active),
        .STATUS_WORD(sw), .FLAGS(flg));

    mwm_ctrl_model u_ctrl (.clk(clk), .ack(ack), .req(preq));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic par(input logic w, input logic r, input logic [15:0] n,
                       input logic [31:0] d, input mwm_exp_s x);
        q.push_back(x);
        u_ctrl.access(w, r, n, d);
    endtask

    task automatic swc(input int b, input logic v, input int n);
        cyc(n);
        check("status bit", {31'h0, sw[b]}, {31'h0, v});
    endtask

    // ******************************
    // Answer monitor
    // ******************************
    always @(posedge clk)
    begin
        #1;
        if (ack === 1'b1)
        begin
            if (q.size() == 0)
                check("unexpected ack", 32'h1, 32'h0);
            else
            begin
                e = q.pop_front();
                check("par err", {31'h0, err}, {31'h0, e.err});
                if (e.chk)
                    check("par rdata", rdata, e.d);
            end
        end
    end

    // ******************************
    // Watchdog
    // ******************************
    initial
    begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end

    // ******************************
    // Scenarios
    // ******************************
    initial
    begin
        int          i;
        logic [31:0] v;
        void'($urandom(62));
        cyc(2);
        reset = 1'b0;
        for (i = 0; i < 11; i++)
            par(1'b0, 1'b1, PN[i], '0, '{1'b0, 1'b1, RST_WIN});
        // Target and actual position both zero, so reached is already set
        par(1'b0, 1'b1, PN_STATUS_WORD, '0,
            '{1'b0, 1'b1, {16'h0, RST_STATUS | 16'h0400}});
        par(1'b0, 1'b1, 16'h00A4, '0, '{1'b1, 1'b1, 32'h0});
        par(1'b1, 1'b0, PN_STATUS_WORD, 32'h1, '{1'b1, 1'b0, 32'h0});
        for (i = 0; i < 11; i++)
        begin
            v = $urandom();
            par(1'b1, 1'b0, PN[i], v, '{1'b0, 1'b0, 32'h0});
            par(1'b0, 1'b1, PN[i], '0, '{1'b0, 1'b1, (i < 6) ? v : {16'h0, v[15:0]}});
        end
        for (i = 0; i < 11; i++)
            par(1'b1, 1'b0, PN[i], VAL[i], '{1'b0, 1'b0, 32'h0});
        // Following error with scale 2.0 and a 2 ms dwell
        pos_scale = 32'h0002_0000;
        mot.demand_pos = 32'sd1000;
        mot.target_pos = 32'sd985;
        mot.actual_pos = 32'sd1020;
        swc(SW_FOLLOW_ERR, 1'b0, 12);
        swc(SW_REACHED, 1'b0, 0);
        mot.actual_pos = 32'sd1021;
        swc(SW_FOLLOW_ERR, 1'b0, 7);
        swc(SW_FOLLOW_ERR, 1'b1, 7);
        check("pos err flag", {31'h0, flg.pos_err}, 32'h1);
        mot.actual_pos = 32'sd1000;
        swc(SW_FOLLOW_ERR, 1'b0, 5);
        mot.actual_pos = 32'sd979;
        cyc(6);
        mot.actual_pos = 32'sd1000;
        cyc(1);
        mot.actual_pos = 32'sd979;
        swc(SW_FOLLOW_ERR, 1'b0, 8);
        swc(SW_FOLLOW_ERR, 1'b1, 6);
        // Target reach at the window edge
        mot.actual_pos = 32'sd980;
        swc(SW_REACHED, 1'b1, 5);
        check("pos reach flag", {31'h0, flg.pos_reach}, 32'h1);
        // Clock enable low freezes the status
        ce = 1'b0;
        mot.actual_pos = 32'sd3000;
        swc(SW_REACHED, 1'b1, 10);
        ce = 1'b1;
        swc(SW_FOLLOW_ERR, 1'b1, 14);
        swc(SW_REACHED, 1'b0, 0);
        mot.actual_pos = 32'sd1000;
        // Standstill with a 1 ms dwell and overspeed
        mot.actual_vel = -32'sd100;
        swc(SW_STANDSTILL, 1'b1, 10);
        mot.actual_vel = -32'sd101;
        swc(SW_STANDSTILL, 1'b1, 3);
        swc(SW_STANDSTILL, 1'b0, 6);
        check("moving flag", {31'h0, flg.moving}, 32'h1);
        check("overspeed", {31'h0, flg.overspeed}, 32'h0);
        mot.actual_vel = 32'sd201;
        cyc(3);
        check("overspeed", {31'h0, flg.overspeed}, 32'h1);
        mot.actual_vel = -32'sd200;
        cyc(3);
        check("overspeed", {31'h0, flg.overspeed}, 32'h0);
        mot.actual_vel = 32'sd50;
        swc(SW_STANDSTILL, 1'b1, 4);
        // Velocity mode windows
        vel_mode = 1'b1;
        mot.target_vel = 32'sd1000;
        mot.actual_vel = 32'sd1051;
        swc(SW_FOLLOW_ERR, 1'b1, 5);
        check("vel err flag", {31'h0, flg.vel_err}, 32'h1);
        mot.actual_vel = 32'sd1050;
        swc(SW_FOLLOW_ERR, 1'b0, 5);
        ramp_active = 1'b1;
        mot.actual_vel = 32'sd1010;
        swc(SW_REACHED, 1'b0, 5);
        ramp_active = 1'b0;
        swc(SW_REACHED, 1'b1, 5);
        check("vel reach flag", {31'h0, flg.vel_reach}, 32'h1);
        mot.actual_vel = 32'sd989;
        swc(SW_REACHED, 1'b0, 5);
        // Second reset in mid-run
        reset = 1'b1;
        cyc(1);
        check("status word", {16'h0, sw}, {16'h0, RST_STATUS});
        reset = 1'b0;
        cyc(2);
        par(1'b0, 1'b1, PN[0], '0, '{1'b0, 1'b1, RST_WIN});
        check("pending answers", q.size(), 0);
        complete_run();
    end
endmodule
